// ===== common/msesel_pkg.sv
// Package for the mesh stop event select block: register map, event codes, mask fields
package msesel_pkg;
	localparam logic [11:0] REG_CTRL_OFF   = 12'h000;
	localparam logic [11:0] REG_COUNT_OFF  = 12'h004;
	localparam logic [11:0] REG_STATUS_OFF = 12'h008;

	// Control register layout
	localparam int CTRL_EVT_LSB  = 0;
	localparam int CTRL_MASK_LSB = 8;
	localparam int CTRL_EN_BIT   = 16;
	localparam int CTRL_CLR_BIT  = 17;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0001_ffff;

	// Event codes
	localparam logic [7:0] EVT_HSINK   = 8'had;
	localparam logic [7:0] EVT_VSINK   = 8'hab;
	localparam logic [7:0] EVT_THROTTLE = 8'hae;
	localparam logic [7:0] EVT_PRIO    = 8'he5;
	localparam logic [7:0] EVT_BYPASS  = 8'he2;
	localparam logic [7:0] EVT_CRD     = 8'he3;
	localparam logic [7:0] EVT_CRD1    = 8'he4;
	localparam logic [7:0] EVT_ALLOC   = 8'he1;
	localparam logic [7:0] EVT_FILL    = 8'he0;
	localparam logic [7:0] EVT_REQ_AG0 = 8'hd0;
	localparam logic [7:0] EVT_REQ_AG1 = 8'hd2;
	localparam logic [7:0] EVT_DAT_AG0 = 8'hd4;
	localparam logic [7:0] EVT_DAT_AG1 = 8'hd6;

	// Ring-class condition vector indices (shared by ingress events)
	localparam int RC_REQ_UNCRD = 0;
	localparam int RC_ACK       = 1;
	localparam int RC_DAT_UNCRD = 2;
	localparam int RC_INV       = 3;
	localparam int RC_REQ_CRD   = 4;
	localparam int RC_DAT_CRD5  = 5;
	localparam int RC_DAT_CRD   = 6;
	localparam int RC_TOP       = 7;

	// Legal mask bits per event group
	localparam logic [7:0] HSINK_VALID = 8'h2f;
	localparam logic [7:0] VSINK_VALID = 8'h1f;
	localparam logic [7:0] PRIO_VALID  = 8'h55;
	localparam logic [7:0] RING_VALID  = 8'hdf;
	localparam logic [7:0] FILL_VALID  = 8'hbf;
	localparam logic [7:0] STALL_VALID = 8'hff;

	localparam logic [31:0] SLVERR_NONE = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
endpackage

// ===== rtl/msesel_top.sv
// Mesh stop performance event selection, counter and APB register slave
// Functional notes
// - 0xAD counts horizontal sink starvation per ring
// - 0xAB counts vertical sink starvation per ring
// - 0xAE counts source throttle, no mask
// - Count cycles while ingress injection starved
// - 0xE5 counts starvation from other queue priority
// - Ring classes: credited and uncredited mask bits
// - 0xE2 counts ingress bypass packets by class
// - 0xE3/0xE4 credit starvation; both take mask bits 0xdf
// - 0xE1 counts ingress allocations by class
// - Ingress bits: 1 ack, 3 invalidate, 7 ack-core
// - 0xE0 counts cycles any selected class is non-empty; data credited bit 5
// - 0xD0 agent0 request egress credit stalls
// - 0xD2 agent1 request egress credit stalls
// - 0xD4/0xD6 agent0/agent1 data egress stalls
// - Stall mask bit k selects transgress port k
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module msesel_top
	import msesel_pkg::*;
(
	input  wire logic        clk_i,                // 125 MHz uncore clock
	input  wire logic        rst_n_i,              // Synchronous reset, active low
	input  wire logic        psel_i,               // APB select
	input  wire logic        penable_i,            // APB enable
	input  wire logic        pwrite_i,             // APB write
	input  wire logic [11:0] paddr_i,              // APB byte address
	input  wire logic [31:0] pwdata_i,             // APB write data
	output logic      [31:0] prdata_o,             // APB read data
	output logic             pready_o,             // APB ready
	output logic             pslverr_o,            // APB error, unmapped address
	input  wire logic [7:0]  horizontal_sink_starve_event_i,  // Per-ring horizontal sink starve
	input  wire logic [7:0]  vertical_sink_starve_event_i,    // Per-ring vertical sink starve
	input  wire logic        source_throttle_event_i,         // Horizontal source throttle
	input  wire logic        ingress_starve_mode_i,           // Ingress in injection starvation
	input  wire logic [7:0]  ingress_priority_starve_event_i, // Per class, other queue wins
	input  wire logic [7:0]  ingress_bypass_event_i,          // Per class bypass packet
	input  wire logic [7:0]  ingress_credit_starve_event_i,   // Per class credit starve (0xE3)
	input  wire logic [7:0]  ingress_credit_starve1_event_i,  // Per class credit starve (0xE4)
	input  wire logic [7:0]  ingress_alloc_event_i,           // Per class allocation
	input  wire logic [7:0]  ingress_fill_event_i,            // Per class non-empty occupancy
	input  wire logic [7:0]  req_agent0_credit_stall_i,       // Per transgress port stall
	input  wire logic [7:0]  req_agent1_credit_stall_i,       // Per transgress port stall
	input  wire logic [7:0]  data_agent0_credit_stall_i,      // Per transgress port stall
	input  wire logic [7:0]  data_agent1_credit_stall_i,      // Per transgress port stall
	output logic             count_pulse_o                    // Registered copy of increment
);

	typedef enum logic [2:0] {
		MSESEL_IDLE   = 3'b001,
		MSESEL_ACCESS = 3'b010,
		MSESEL_DONE   = 3'b100
	} msesel_state_t;

	msesel_state_t state;
	msesel_state_t next_state;
	logic [31:0]   ctrl;
	logic [31:0]   count;
	logic          hit;
	logic [7:0]    evt_code;
	logic [7:0]    sub_mask;
	logic          known_code;
	logic [7:0]    cond;
	logic [7:0]    valid_bits;
	logic          wr_ctrl;
	logic          setup;
	logic          rd_setup;
	logic          wr_access;
	logic          throttle_sel;
	logic          clr_req;
	logic          count_inc;
	logic          next_pslverr;
	logic [31:0]   next_prdata;
	logic [31:0]   next_ctrl;
	logic [31:0]   next_count;
	logic [31:0]   status_word;

	// Mask the ANDed condition vector against mask, then OR-reduce
	function automatic logic sel_any(input logic [7:0] c, input logic [7:0] m, input logic [7:0] v);
		sel_any = |(c & m & v);
	endfunction

	// Register map decode
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == REG_CTRL_OFF) || (a == REG_COUNT_OFF) || (a == REG_STATUS_OFF);
	endfunction

	assign evt_code = ctrl[CTRL_EVT_LSB +: 8];
	assign sub_mask = ctrl[CTRL_MASK_LSB +: 8];
	assign setup    = psel_i && !penable_i;
	assign rd_setup = setup && !pwrite_i;
	assign throttle_sel = (evt_code == EVT_THROTTLE);

	// Event decode: choose condition vector and legal mask bits
	always_comb begin
		cond       = 8'h00;
		valid_bits = 8'h00;
		known_code = 1'b1;
		case (evt_code)
			EVT_HSINK: begin
				cond       = horizontal_sink_starve_event_i;
				valid_bits = HSINK_VALID;
			end
			EVT_VSINK: begin
				cond       = vertical_sink_starve_event_i;
				valid_bits = VSINK_VALID;
			end
			EVT_THROTTLE: begin
				cond       = 8'h00;
				valid_bits = 8'h00;
			end
			EVT_PRIO: begin
				cond       = ingress_priority_starve_event_i & {8{ingress_starve_mode_i}};
				valid_bits = PRIO_VALID;
			end
			EVT_BYPASS: begin
				cond       = ingress_bypass_event_i;
				valid_bits = RING_VALID;
			end
			EVT_CRD: begin
				cond       = ingress_credit_starve_event_i & {8{ingress_starve_mode_i}};
				valid_bits = RING_VALID | (8'h01 << RC_TOP);
			end
			EVT_CRD1: begin
				cond       = ingress_credit_starve1_event_i & {8{ingress_starve_mode_i}};
				valid_bits = RING_VALID;
			end
			EVT_ALLOC: begin
				cond       = ingress_alloc_event_i;
				valid_bits = RING_VALID;
			end
			EVT_FILL: begin
				cond       = ingress_fill_event_i;
				valid_bits = FILL_VALID;
			end
			EVT_REQ_AG0: begin
				cond       = req_agent0_credit_stall_i;
				valid_bits = STALL_VALID;
			end
			EVT_REQ_AG1: begin
				cond       = req_agent1_credit_stall_i;
				valid_bits = STALL_VALID;
			end
			EVT_DAT_AG0: begin
				cond       = data_agent0_credit_stall_i;
				valid_bits = STALL_VALID;
			end
			EVT_DAT_AG1: begin
				cond       = data_agent1_credit_stall_i;
				valid_bits = STALL_VALID;
			end
			default: begin
				known_code = 1'b0;
			end
		endcase
	end

	// Throttle has no mask: any enable counts it
	always_comb begin
		if (throttle_sel) begin
			hit = source_throttle_event_i;
		end else begin
			hit = known_code && sel_any(cond, sub_mask, valid_bits);
		end
	end

	// Status bit 1: code recognised, bit 0: live hit
	assign status_word = {30'h0, known_code, hit};

	// APB handshake: setup, one access cycle with pready high
	always_comb begin
		next_state = MSESEL_IDLE;
		case (state)
			MSESEL_IDLE: begin
				if (setup) begin
					next_state = MSESEL_ACCESS;
				end
			end
			MSESEL_ACCESS: begin
				next_state = MSESEL_DONE;
			end
			MSESEL_DONE: begin
				if (setup) begin
					next_state = MSESEL_ACCESS;
				end
			end
			default: begin
				next_state = MSESEL_IDLE;
			end
		endcase
	end

	// Handshake state, back to idle on reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= MSESEL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Read mux: the word is taken at the setup edge and stands in the access cycle
	always_comb begin
		next_prdata = SLVERR_NONE;
		if (rd_setup) begin
			case (paddr_i)
				REG_CTRL_OFF: begin
					next_prdata = ctrl & CTRL_WMASK;
				end
				REG_COUNT_OFF: begin
					next_prdata = count;
				end
				REG_STATUS_OFF: begin
					next_prdata = status_word;
				end
				default: begin
					next_prdata = SLVERR_NONE;
				end
			endcase
		end
	end

	// Unmapped addresses are refused in the access cycle
	assign next_pslverr = setup && !addr_hit(paddr_i);

	// pready is high in the access cycle that follows the setup edge
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= setup;
		end
	end

	// Error flag stands with pready for one cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= next_pslverr;
		end
	end

	// Read data is zero outside the access cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= SLVERR_NONE;
		end else begin
			prdata_o <= next_prdata;
		end
	end

	// A write lands at the end of the access cycle the state machine tracks
	assign wr_access = (state == MSESEL_ACCESS) && psel_i && penable_i && pwrite_i;
	assign wr_ctrl   = wr_access && (paddr_i == REG_CTRL_OFF);
	assign clr_req   = wr_ctrl && pwdata_i[CTRL_CLR_BIT];

	// The clear bit is a strobe and is never stored
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl = pwdata_i & CTRL_WMASK & ~(32'h0000_0001 << CTRL_CLR_BIT);
		end
	end

	// Control word holds code, mask and enable
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl <= CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	assign count_inc = ctrl[CTRL_EN_BIT] && hit;

	// Clear wins over an increment in the same cycle
	always_comb begin
		next_count = count;
		if (clr_req) begin
			next_count = COUNT_RESET;
		end else if (count_inc) begin
			next_count = count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count <= COUNT_RESET;
		end else begin
			count <= next_count;
		end
	end

	// One-cycle pulse per counted cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count_pulse_o <= 1'b0;
		end else begin
			count_pulse_o <= count_inc;
		end
	end

endmodule

// ===== dv/msesel_top_checker.sv
// Port checker for the mesh stop event select block
`timescale 1ns/100ps
module msesel_top_checker
	import msesel_pkg::*;
(
	input wire logic        clk_i,                     // Clock
	input wire logic        rst_n_i,                   // Reset
	input wire logic        psel_i,                    // Select
	input wire logic        penable_i,                 // Enable
	input wire logic        pwrite_i,                  // Write
	input wire logic [11:0] paddr_i,                   // Address
	input wire logic [31:0] pwdata_i,                  // Write data
	input wire logic [31:0] prdata_o,                  // Read data
	input wire logic        pready_o,                  // Ready
	input wire logic        pslverr_o,                 // Error
	input wire logic        source_throttle_event_i,   // Throttle
	input wire logic [7:0]  req_agent0_credit_stall_i, // Stalls
	input wire logic        count_pulse_o              // Count pulse
);
	logic [16:0] ctl;
	logic        setup;
	logic        quiet;
	logic        mapped;
	assign setup = psel_i && !penable_i;
	assign quiet = !(psel_i && pwrite_i);
	assign mapped = paddr_i inside {REG_CTRL_OFF, REG_COUNT_OFF, REG_STATUS_OFF};
	// Shadow of the control word as software last wrote it
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			ctl <= '0;
		else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == REG_CTRL_OFF)
			ctl <= pwdata_i[16:0];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ready_after_setup: assert property (setup |=> pready_o) else $error("no ready after setup");
	a_err_needs_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
	a_idle_data_zero: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data not zero");
	a_unmapped_err: assert property (setup && !mapped |=> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_no_err: assert property (setup && mapped |=> !pslverr_o) else $error("mapped access refused");
	a_pulse_needs_en: assert property (count_pulse_o |-> $past(ctl[16]))
		else $error("count while disabled");
	a_throttle_counts: assert property (ctl[16] && ctl[7:0] == EVT_THROTTLE && source_throttle_event_i && quiet
		|=> count_pulse_o) else $error("throttle not counted");
	a_stall_port_counts: assert property (ctl[16] && ctl[7:0] == EVT_REQ_AG0 && quiet
		&& |(ctl[15:8] & req_agent0_credit_stall_i) |=> count_pulse_o) else $error("stall not counted");
endmodule
bind msesel_top msesel_top_checker u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.prdata_o, .pready_o, .pslverr_o, .source_throttle_event_i, .req_agent0_credit_stall_i, .count_pulse_o);

// ===== dv/msesel_top_bench.sv
// Self-checking bench for the mesh stop event select block
`timescale 1ns/100ps
module msesel_top_bench import msesel_pkg::*;;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic        thr = 1'b0, smode = 1'b0, pready_o, pslverr_o, pulse;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, seed = 32'd21677;
	logic [7:0]  ev [12] = '{default: 8'h00};
	logic [32:0] expq [$];
	int          err_count = 0, tests_run = 0, pulses = 0;
	msesel_top u_dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .horizontal_sink_starve_event_i(ev[0]), .vertical_sink_starve_event_i(ev[1]),
		.source_throttle_event_i(thr), .ingress_starve_mode_i(smode), .ingress_priority_starve_event_i(ev[2]),
		.ingress_bypass_event_i(ev[3]), .ingress_credit_starve_event_i(ev[4]),
		.ingress_credit_starve1_event_i(ev[5]), .ingress_alloc_event_i(ev[6]), .ingress_fill_event_i(ev[7]),
		.req_agent0_credit_stall_i(ev[8]), .req_agent1_credit_stall_i(ev[9]), .data_agent0_credit_stall_i(ev[10]),
		.data_agent1_credit_stall_i(ev[11]), .count_pulse_o(pulse));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected increment for the values the design samples at this edge
	function automatic logic hit(input logic [7:0] c, input logic [7:0] m);
		case (c)
			EVT_HSINK: return |(ev[0] & m & 8'h2f);
			EVT_VSINK: return |(ev[1] & m & 8'h1f);
			EVT_THROTTLE: return thr;
			EVT_PRIO: return smode & |(ev[2] & m & 8'h55);
			EVT_BYPASS: return |(ev[3] & m & 8'hdf);
			EVT_CRD: return smode & |(ev[4] & m & 8'hdf);
			EVT_CRD1: return smode & |(ev[5] & m & 8'hdf);
			EVT_ALLOC: return |(ev[6] & m & 8'hdf);
			EVT_FILL: return |(ev[7] & m & 8'hbf);
			EVT_REQ_AG0: return |(ev[8] & m);
			EVT_REQ_AG1: return |(ev[9] & m);
			EVT_DAT_AG0: return |(ev[10] & m);
			EVT_DAT_AG1: return |(ev[11] & m);
			default: return 1'b0;
		endcase
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		if (!w)
			expq.push_back(e);
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1)
			@(posedge clk_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic close_out();
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
			logic [32:0] e;
			e = expq.size() > 0 ? expq.pop_front() : 'x;
			tests_run++;
			if ({pslverr_o, prdata_o} !== e) begin
				err_count++;
				$display("BAD read %h exp %h seen %h", paddr_i, e, {pslverr_o, prdata_o});
			end
		end
	end
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (pulse === 1'b1)
			pulses++;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		close_out();
	end
	initial begin
		logic [7:0]  codes [14];
		logic [31:0] w;
		logic [31:0] r;
		int          total;
		codes = '{EVT_HSINK, EVT_VSINK, EVT_THROTTLE, EVT_PRIO, EVT_BYPASS, EVT_CRD, EVT_CRD1, EVT_ALLOC, EVT_FILL,
			EVT_REQ_AG0, EVT_REQ_AG1, EVT_DAT_AG0, EVT_DAT_AG1, 8'haf};
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		apb(0, REG_CTRL_OFF, 0, {1'b0, CTRL_RESET});
		apb(0, REG_COUNT_OFF, 0, 33'h0);
		for (int p = 0; p < 3; p++) begin
			foreach (codes[k]) begin
				w = rnd();
				// Clear on every write; first pass selects every mask bit
				w = {14'h0, 1'b1, p < 2 || w[20], p == 0 ? 8'hff : w[15:8], codes[k]};
				apb(1, REG_CTRL_OFF, w, 33'h0);
				apb(0, REG_CTRL_OFF, 0, {1'b0, w & CTRL_WMASK});
				apb(0, REG_STATUS_OFF, 0, {31'h0, codes[k] != 8'haf, 1'b0});
				total = 0;
				pulses = 0;
				repeat (25) begin
					@(posedge clk_i);
					total += hit(codes[k], w[15:8]);
					foreach (ev[i]) ev[i] <= 8'(rnd());
					r = rnd();
					thr <= r[3];
					smode <= r[9];
				end
				@(posedge clk_i);
				total += hit(codes[k], w[15:8]);
				foreach (ev[i]) ev[i] <= 8'h00;
				thr <= 1'b0;
				smode <= 1'b0;
				apb(1, REG_COUNT_OFF, rnd(), 33'h0);
				apb(0, REG_COUNT_OFF, 0, {1'b0, w[16] ? 32'(total) : 32'h0});
				tests_run++;
				if (pulses != (w[16] ? total : 0)) begin
					err_count++;
					$display("BAD pulses exp %0d seen %0d", w[16] ? total : 0, pulses);
				end
			end
		end
		apb(1, 12'h00c, 32'hffff_ffff, 33'h0);
		apb(0, 12'h00c, 0, {1'b1, 32'h0});
		close_out();
	end
endmodule
